/* logic/pid_loop.sv */
// pid loop engine with apb registers and pulse-width actuator output
//
// Function
// - reverse direction inverts the error sign
// - integral frozen toward the limit at which output is saturated
// - enhanced mode suppresses integral on setpoint drop
// - pwm pin on-time once per output period
// - pwm period counted in 0.1 ms units
// - pwm pin selectable from P20 to P3F
// - computation once per cycle in 0.1 ms units
// - gain, integral time, derivative time scale terms
// - nonzero input change limit bounds process value
// - nonzero output change limit bounds output step
// - above maximum clamps output and warns
// - below minimum clamps output and warns
// - manual mode outputs the manual value
// - inside deadband the error is zero
// - derivative uses filtered value, zero disables filter
// - setpoint change ramps in equal steps
// - start or auto return ramps from process value
// - setpoint change during follow-up uses ramp
// - process value clamped to signed bounds
// - automatic mode outputs computed result, default
// - run, warning and error flags with codes
`timescale 1ns/1ns
module pid_loop #(
  parameter int UNIT_CYCLES = pid_pkg::UNIT_CYCLES
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pid_pkg::pid_apb_req_s apb_req,
  output pid_pkg::pid_apb_resp_s apb_resp,
  input wire logic [15:0] process_value,
  output logic [31:0] pwm_pins
);
  import pid_pkg::*;

  pid_state_s s_reg;
  pid_state_s s_next;

  always_comb begin
    logic [5:0] idx;
    logic valid;
    logic unit_tick;
    logic op_tick;
    logic dgo;
    logic signed [47:0] dnum;
    logic [47:0] mag;
    logic [31:0] dden;
    logic [32:0] rem_t;
    logic signed [47:0] quot;
    logic signed [16:0] pvc;
    logic signed [16:0] dlt;
    logic signed [16:0] lim;
    logic signed [31:0] e32;
    logic signed [31:0] acc_n;
    logic signed [63:0] p64;
    logic signed [63:0] d64;
    logic signed [63:0] raw;
    logic signed [63:0] mvc;
    logic signed [63:0] dmv;
    logic signed [63:0] lim64;
    logic [7:0] pin;
    logic pwm_on;
    idx = apb_req.paddr[7:2];
    valid = 1'b0;
    unit_tick = 1'b0;
    op_tick = 1'b0;
    dgo = 1'b0;
    dnum = '0;
    mag = '0;
    dden = 32'h0000_0001;
    rem_t = '0;
    quot = '0;
    pvc = '0;
    dlt = '0;
    lim = '0;
    e32 = '0;
    acc_n = '0;
    p64 = '0;
    d64 = '0;
    raw = '0;
    mvc = '0;
    dmv = '0;
    lim64 = '0;
    pin = '0;
    pwm_on = 1'b0;
    s_next = s_reg;

    // apb: read data captured in the setup cycle, writes in access
    valid = (int'(idx) < NREG) && (apb_req.paddr[1:0] == 2'b00);
    if (apb_req.psel && !apb_req.penable) begin
      s_next.prdata = 32'h0000_0000;
    end
    // a misaligned offset into a mapped word still reads zero
    if (apb_req.psel && !apb_req.penable && valid) begin
      case (int'(idx))
        R_STATUS: begin
          s_next.prdata[STAT_RUN] = s_reg.cfg[R_CTRL][CTRL_RUN];
          s_next.prdata[STAT_WARN] = s_reg.warn;
          s_next.prdata[STAT_ERR] = s_reg.errf;
          s_next.prdata[15:8] = s_reg.warn_code;
          s_next.prdata[23:16] = s_reg.err_code;
        end
        R_MV: s_next.prdata[15:0] = s_reg.mv;
        R_CURSV: s_next.prdata[15:0] = s_reg.wsp;
        R_PVUSE: s_next.prdata[15:0] = s_reg.pv_used;
        default: begin
          if (int'(idx) < NCFG) begin
            s_next.prdata[15:0] = s_reg.cfg[idx[4:0]];
          end
        end
      endcase
    end
    if (apb_req.psel && apb_req.penable && apb_req.pwrite && valid) begin
      if (int'(idx) == R_STATUS) begin
        // write one to clear; a same-cycle event below sets it again
        if (apb_req.pwdata[STAT_WARN]) begin
          s_next.warn = 1'b0;
        end
        if (apb_req.pwdata[STAT_ERR]) begin
          s_next.errf = 1'b0;
        end
      end else if (int'(idx) < NCFG) begin
        s_next.cfg[idx[4:0]] = apb_req.pwdata[15:0];
      end
    end

    // process value: three stages, taken once two agree
    s_next.pv_s1 = process_value;
    s_next.pv_s2 = s_reg.pv_s1;
    s_next.pv_s3 = s_reg.pv_s2;
    if (s_reg.pv_s2 == s_reg.pv_s3) begin
      s_next.pv_stable = s_reg.pv_s3;
    end

    // 0.1 ms time base shared by the loop and the pwm
    if (s_reg.unit_cnt == 32'(UNIT_CYCLES - 1)) begin
      s_next.unit_cnt = '0;
      unit_tick = 1'b1;
    end else begin
      s_next.unit_cnt = s_reg.unit_cnt + 32'h0000_0001;
    end
    if (unit_tick) begin
      if (s_reg.op_cnt + 16'h0001 >= s_reg.cfg[R_CYCLE]) begin
        s_next.op_cnt = '0;
        op_tick = 1'b1;
      end else begin
        s_next.op_cnt = s_reg.op_cnt + 16'h0001;
      end
      if (s_reg.pwm_phase + 16'h0001 >= s_reg.cfg[R_PWMPRD]) begin
        s_next.pwm_phase = '0;
        s_next.duty = s_reg.duty_next;
      end else begin
        s_next.pwm_phase = s_reg.pwm_phase + 16'h0001;
      end
    end

    // start, auto return and setpoint edits
    s_next.run_d = s_reg.cfg[R_CTRL][CTRL_RUN];
    s_next.man_d = s_reg.cfg[R_CTRL][CTRL_MAN];
    if (s_reg.cfg[R_CTRL][CTRL_RUN] && (!s_reg.run_d ||
        (s_reg.man_d && !s_reg.cfg[R_CTRL][CTRL_MAN]))) begin
      s_next.wsp = s_reg.pv_stable;
      s_next.pv_used = s_reg.pv_stable;
      s_next.pv_f = 32'(s_reg.pv_stable);
      s_next.ramp_left = s_reg.cfg[R_TRACK];
      s_next.sv_last = s_reg.cfg[R_SV];
    end else if (s_reg.cfg[R_SV] != s_reg.sv_last) begin
      // a new target restarts the ramp from where the setpoint now is
      s_next.sv_last = s_reg.cfg[R_SV];
      s_next.ramp_left = s_reg.cfg[R_RAMP];
      if ($signed(s_reg.cfg[R_SV]) < $signed(s_reg.sv_last)) begin
        s_next.sv_drop = 1'b1;
      end
    end

    // serial divider, one quotient bit per clock
    quot = s_reg.div_neg ? -$signed(s_reg.div_quo) : $signed(s_reg.div_quo);
    if (s_reg.div_busy) begin
      rem_t = {s_reg.div_rem[31:0], s_reg.div_quo[47]};
      s_next.div_quo = {s_reg.div_quo[46:0], 1'b0};
      if (rem_t >= {1'b0, s_reg.div_den}) begin
        rem_t = rem_t - {1'b0, s_reg.div_den};
        s_next.div_quo[0] = 1'b1;
      end
      s_next.div_rem = rem_t;
      s_next.div_cnt = s_reg.div_cnt + 6'h01;
      if (s_reg.div_cnt == DIV_LAST) begin
        s_next.div_busy = 1'b0;
      end
    end

    case (s_reg.st)
      ST_IDLE: begin
        if (op_tick && s_reg.cfg[R_CTRL][CTRL_RUN]) begin
          if (s_reg.cfg[R_CYCLE] < CYCLE_MIN) begin
            s_next.errf = 1'b1;
            s_next.err_code = ERR_CYCLE;
          end else if ($signed(s_reg.cfg[R_MVMAX]) <
                       $signed(s_reg.cfg[R_MVMIN])) begin
            s_next.errf = 1'b1;
            s_next.err_code = ERR_MV_RANGE;
          end else if (s_reg.cfg[R_PWMPRD] < PRD_MIN) begin
            s_next.errf = 1'b1;
            s_next.err_code = ERR_PWM_PRD;
          end else begin
            pvc = 17'(s_reg.pv_stable);
            if (pvc < $signed(s_reg.cfg[R_PVMIN])) begin
              pvc = 17'($signed(s_reg.cfg[R_PVMIN]));
            end
            if (pvc > $signed(s_reg.cfg[R_PVMAX])) begin
              pvc = 17'($signed(s_reg.cfg[R_PVMAX]));
            end
            dlt = pvc - 17'(s_reg.pv_used);
            lim = $signed({1'b0, s_reg.cfg[R_DPV]});
            if (lim != 0 && dlt > lim) begin
              pvc = 17'(s_reg.pv_used) + lim;
            end else if (lim != 0 && dlt < -lim) begin
              pvc = 17'(s_reg.pv_used) - lim;
            end
            s_next.pv_used = pvc[15:0];
            dgo = 1'b1;
            dnum = 48'($signed(s_reg.cfg[R_SV])) - 48'(s_reg.wsp);
            if (s_reg.ramp_left > 16'h0001) begin
              dden = {16'h0000, s_reg.ramp_left};
            end
            s_next.st = ST_RAMP;
          end
        end
      end
      ST_RAMP: begin
        if (!s_reg.div_busy) begin
          if (s_reg.ramp_left > 16'h0001) begin
            s_next.wsp = s_reg.wsp + quot[15:0];
            s_next.ramp_left = s_reg.ramp_left - 16'h0001;
          end else begin
            s_next.wsp = s_reg.cfg[R_SV];
            s_next.ramp_left = '0;
          end
          dlt = 17'(s_reg.pv_used) - 17'(s_next.wsp);
          e32 = s_reg.cfg[R_CTRL][CTRL_REV] ? 32'(dlt) : -32'(dlt);
          if (s_reg.cfg[R_DB] != 16'h0000 &&
              (dlt <= $signed({1'b0, s_reg.cfg[R_DB]})) &&
              (dlt >= -$signed({1'b0, s_reg.cfg[R_DB]}))) begin
            e32 = '0;
          end
          s_next.err = e32;
          // filter step divides by coefficient+1; zero passes straight
          dgo = 1'b1;
          dnum = 48'(s_reg.pv_used) - 48'(s_reg.pv_f);
          dden = {16'h0000, s_reg.cfg[R_FILT]} + 32'h0000_0001;
          s_next.st = ST_FILT;
        end
      end
      ST_FILT: begin
        if (!s_reg.div_busy) begin
          s_next.pv_f_old = s_reg.pv_f;
          s_next.pv_f = s_reg.pv_f + quot[31:0];
          acc_n = s_reg.acc;
          if (s_reg.cfg[R_CTRL][CTRL_AW2] && s_reg.sv_drop) begin
            // setpoint fell: drop any positive build-up, skip this sample
            if (acc_n > 0) begin
              acc_n = '0;
            end
            s_next.sv_drop = 1'b0;
          end else if (!(s_reg.sat_hi && s_reg.err > 0) &&
                       !(s_reg.sat_lo && s_reg.err < 0)) begin
            acc_n = s_reg.acc + s_reg.err;
          end
          s_next.acc = acc_n;
          // accumulator times gain must stay inside 48 bits
          dgo = 1'b1;
          if (s_reg.cfg[R_TI] != 16'h0000) begin
            dnum = 48'(acc_n) * 48'({1'b0, s_reg.cfg[R_KP]});
            dden = {16'h0000, s_reg.cfg[R_TI]};
          end
          s_next.st = ST_INTEG;
        end
      end
      ST_INTEG: begin
        if (!s_reg.div_busy) begin
          s_next.i_term = 32'(quot >>> FRAC_BITS);
          s_next.st = ST_OUT;
        end
      end
      ST_OUT: begin
        // gains kept signed so a negative product shifts arithmetically
        p64 = (64'(s_reg.err) *
               64'($signed({1'b0, s_reg.cfg[R_KP]}))) >>> FRAC_BITS;
        d64 = (64'(s_reg.pv_f - s_reg.pv_f_old) *
               64'($signed({1'b0, s_reg.cfg[R_KP]})) *
               64'($signed({1'b0, s_reg.cfg[R_TD]}))) >>> FRAC_BITS;
        // derivative on the measurement, sign follows direction
        raw = s_reg.cfg[R_CTRL][CTRL_REV] ? p64 + 64'(s_reg.i_term) + d64
                                          : p64 + 64'(s_reg.i_term) - d64;
        mvc = raw;
        s_next.sat_hi = 1'b0;
        s_next.sat_lo = 1'b0;
        if (raw > 64'($signed(s_reg.cfg[R_MVMAX]))) begin
          mvc = 64'($signed(s_reg.cfg[R_MVMAX]));
          s_next.sat_hi = 1'b1;
          s_next.warn = 1'b1;
          s_next.warn_code = WARN_MV_HI;
        end else if (raw < 64'($signed(s_reg.cfg[R_MVMIN]))) begin
          mvc = 64'($signed(s_reg.cfg[R_MVMIN]));
          s_next.sat_lo = 1'b1;
          s_next.warn = 1'b1;
          s_next.warn_code = WARN_MV_LO;
        end
        dmv = mvc - 64'(s_reg.mv);
        lim64 = 64'({1'b0, s_reg.cfg[R_DMV]});
        if (lim64 != 0 && dmv > lim64) begin
          mvc = 64'(s_reg.mv) + lim64;
        end else if (lim64 != 0 && dmv < -lim64) begin
          mvc = 64'(s_reg.mv) - lim64;
        end
        if (s_reg.cfg[R_CTRL][CTRL_MAN]) begin
          s_next.mv = s_reg.cfg[R_MVMAN];
        end else begin
          s_next.mv = mvc[15:0];
        end
        dgo = 1'b1;
        dnum = 48'({1'b0, s_reg.cfg[R_PWMPRD]}) *
               (48'(s_next.mv) - 48'($signed(s_reg.cfg[R_MVMIN])));
        dden = 32'(48'($signed(s_reg.cfg[R_MVMAX])) -
                   48'($signed(s_reg.cfg[R_MVMIN])));
        if (dden == 32'h0000_0000) begin
          dnum = '0;
          dden = 32'h0000_0001;
        end
        s_next.st = ST_DUTY;
      end
      ST_DUTY: begin
        if (!s_reg.div_busy) begin
          // takes effect at the next period start, never mid-pulse
          s_next.duty_next = quot[15:0];
          s_next.st = ST_IDLE;
        end
      end
      default: s_next.st = ST_IDLE;
    endcase

    if (dgo) begin
      mag = (dnum < 0) ? 48'(-dnum) : 48'(dnum);
      s_next.div_busy = 1'b1;
      s_next.div_cnt = '0;
      s_next.div_rem = '0;
      s_next.div_quo = mag;
      s_next.div_den = dden;
      s_next.div_neg = dnum < 0;
    end

    // stopped loops keep their output but drive no pulse
    pin = s_reg.cfg[R_PWMPIN][7:0];
    pwm_on = s_reg.cfg[R_CTRL][CTRL_RUN] && s_reg.cfg[R_CTRL][CTRL_PWM] &&
             (s_next.pwm_phase < s_next.duty);
    for (int i = 0; i < 32; i++) begin
      s_next.pwm_out[i] = pwm_on && (pin >= PIN_FIRST) && (pin <= PIN_LAST) &&
                          (pin - PIN_FIRST == 8'(i));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
      s_reg.st <= ST_IDLE;
      for (int i = 0; i < NCFG; i++) begin
        s_reg.cfg[i] <= pid_cfg_reset(i);
      end
      s_reg.sv_last <= pid_cfg_reset(R_SV);
    end else begin
      s_reg <= s_next;
    end
  end

  assign apb_resp.prdata = s_reg.prdata;
  assign apb_resp.pready = 1'b1;
  assign apb_resp.pslverr = apb_req.psel && apb_req.penable &&
                            !((int'(apb_req.paddr[7:2]) < NREG) &&
                              (apb_req.paddr[1:0] == 2'b00));
  assign pwm_pins = s_reg.pwm_out;
endmodule : pid_loop

/* logic/pid_pkg.sv */
// constants, register map and types of the pid loop engine
package pid_pkg;
  // register indices; the byte address is four times the index
  localparam int R_CTRL = 0;
  localparam int R_STATUS = 1;
  localparam int R_SV = 2;
  localparam int R_CYCLE = 3;
  localparam int R_KP = 4;
  localparam int R_TI = 5;
  localparam int R_TD = 6;
  localparam int R_DPV = 7;
  localparam int R_DMV = 8;
  localparam int R_MVMAX = 9;
  localparam int R_MVMIN = 10;
  localparam int R_MVMAN = 11;
  localparam int R_DB = 12;
  localparam int R_FILT = 13;
  localparam int R_PWMPIN = 14;
  localparam int R_PWMPRD = 15;
  localparam int R_RAMP = 16;
  localparam int R_TRACK = 17;
  localparam int R_PVMIN = 18;
  localparam int R_PVMAX = 19;
  localparam int R_MV = 20;
  localparam int R_CURSV = 21;
  localparam int R_PVUSE = 22;
  localparam int NCFG = 20;
  localparam int NREG = 23;

  localparam int CTRL_RUN = 0;
  localparam int CTRL_MAN = 1;
  localparam int CTRL_REV = 2;
  localparam int CTRL_AW2 = 3;
  localparam int CTRL_PWM = 4;
  localparam int STAT_RUN = 0;
  localparam int STAT_WARN = 1;
  localparam int STAT_ERR = 2;

  localparam logic [7:0] WARN_MV_HI = 8'h01;
  localparam logic [7:0] WARN_MV_LO = 8'h02;
  localparam logic [7:0] ERR_CYCLE = 8'h01;
  localparam logic [7:0] ERR_MV_RANGE = 8'h02;
  localparam logic [7:0] ERR_PWM_PRD = 8'h03;

  localparam logic [15:0] CYCLE_MIN = 16'h0064;
  localparam logic [15:0] PRD_MIN = 16'h0064;
  localparam logic [7:0] PIN_FIRST = 8'h20;
  localparam logic [7:0] PIN_LAST = 8'h3F;

  localparam int UNIT_NS = 100000;
  localparam int CLK_NS = 8;
  localparam int UNIT_CYCLES = UNIT_NS / CLK_NS;
  localparam int FRAC_BITS = 8;
  localparam logic [5:0] DIV_LAST = 6'h2F;

  function automatic logic [15:0] pid_cfg_reset(input int i);
    case (i)
      R_CYCLE: return 16'h0064;
      R_KP: return 16'h0100;
      R_MVMAX: return 16'h0FA0;
      R_PWMPIN: return 16'h0020;
      R_PWMPRD: return 16'h0064;
      R_PVMAX: return 16'h0FA0;
      default: return 16'h0000;
    endcase
  endfunction : pid_cfg_reset

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } pid_apb_req_s;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } pid_apb_resp_s;

  typedef enum logic [5:0] {
    ST_IDLE = 6'b000001,
    ST_RAMP = 6'b000010,
    ST_FILT = 6'b000100,
    ST_INTEG = 6'b001000,
    ST_OUT = 6'b010000,
    ST_DUTY = 6'b100000
  } pid_state_e;

  typedef struct packed {
    pid_state_e st;
    logic [NCFG-1:0][15:0] cfg;
    logic [31:0] prdata;
    logic [15:0] pv_s1;
    logic [15:0] pv_s2;
    logic [15:0] pv_s3;
    logic signed [15:0] pv_stable;
    logic signed [15:0] pv_used;
    logic signed [31:0] pv_f;
    logic signed [31:0] pv_f_old;
    logic signed [15:0] wsp;
    logic [15:0] ramp_left;
    logic [15:0] sv_last;
    logic sv_drop;
    logic run_d;
    logic man_d;
    logic signed [31:0] acc;
    logic signed [31:0] err;
    logic signed [31:0] i_term;
    logic signed [15:0] mv;
    logic sat_hi;
    logic sat_lo;
    logic warn;
    logic errf;
    logic [7:0] warn_code;
    logic [7:0] err_code;
    logic [31:0] unit_cnt;
    logic [15:0] op_cnt;
    logic [15:0] pwm_phase;
    logic [15:0] duty;
    logic [15:0] duty_next;
    logic [31:0] pwm_out;
    logic div_busy;
    logic [5:0] div_cnt;
    logic [32:0] div_rem;
    logic [47:0] div_quo;
    logic [31:0] div_den;
    logic div_neg;
  } pid_state_s;
endpackage : pid_pkg

/* sim/pid_loop_monitor.sv */
// port assertions for the pid loop engine
`timescale 1ns/1ns
module pid_loop_monitor #(
  parameter int UNIT_CYCLES = 10
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire pid_pkg::pid_apb_req_s apb_req,
  input wire pid_pkg::pid_apb_resp_s apb_resp,
  input wire logic [15:0] process_value,
  input wire logic [31:0] pwm_pins
);
  import pid_pkg::*;
  logic acc;
  logic setup;
  logic [5:0] idx;
  assign acc = apb_req.psel & apb_req.penable;
  assign setup = apb_req.psel & ~apb_req.penable;
  assign idx = apb_req.paddr[7:2];
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  ready_const_a: assert property (acc |-> apb_resp.pready)
    else $error("pready low in access phase");
  unmapped_err_a: assert property (acc && idx >= 6'(NREG) |-> apb_resp.pslverr)
    else $error("no error on unmapped index");
  misalign_err_a: assert property (acc && apb_req.paddr[1:0] != 2'h0
    |-> apb_resp.pslverr)
    else $error("no error on misaligned address");
  mapped_ok_a: assert property (acc && idx < 6'(NREG)
    && apb_req.paddr[1:0] == 2'h0 |-> !apb_resp.pslverr)
    else $error("error on mapped register");
  idle_no_err_a: assert property (!acc |-> !apb_resp.pslverr)
    else $error("error outside access phase");
  err_data_zero_a: assert property (acc && apb_resp.pslverr
    |-> apb_resp.prdata == 32'h0)
    else $error("refused read returned data");
  upper_zero_a: assert property (acc && !apb_req.pwrite && idx != 6'(R_STATUS)
    |-> apb_resp.prdata[31:16] == 16'h0)
    else $error("upper read data not zero");
  rdata_hold_a: assert property (!setup |=> $stable(apb_resp.prdata))
    else $error("read data moved outside setup");
  pin_onehot_a: assert property ($onehot0(pwm_pins))
    else $error("more than one output pin high");
endmodule : pid_loop_monitor

/* sim/pid_plant.sv */
// sensor and actuator pin model at the far side of the pid loop
`timescale 1ns/1ns
module pid_plant (
  input wire logic pclk,
  input wire logic [15:0] pv_set,
  input wire logic [4:0] pin_sel,
  input wire logic [31:0] pwm_pins,
  output logic [15:0] process_value,
  output int on_len
);
  int run;
  initial process_value = 16'h0000;
  initial on_len = 0;
  initial run = 0;
  // sensor moves on an edge only, so the input synchroniser sees it settle
  always @(posedge pclk) begin
    process_value <= pv_set;
    if (pwm_pins[pin_sel]) begin
      run <= run + 1;
    end else begin
      if (run != 0) begin
        on_len <= run;
      end
      run <= 0;
    end
  end
endmodule : pid_plant

/* sim/pid_loop_bench.sv */
// self-checking bench for the pid loop engine
`timescale 1ns/1ns
module pid_loop_bench;
  import pid_pkg::*;
  localparam int UC = 10;
  // one operation cycle of 100 ticks plus the compute pipeline
  localparam int OPC = 100 * UC + 400;
  logic pclk;
  logic presetn;
  pid_apb_req_s req;
  pid_apb_resp_s resp;
  logic [15:0] pv_set;
  logic [4:0] pin_sel;
  logic [15:0] process_value;
  logic [31:0] pwm_pins;
  int on_len;
  int fail_count;
  int n_tests;
  int mdl [0:NREG-1];
  logic [31:0] d;
  logic e;
  int man;

  pid_loop #(.UNIT_CYCLES(UC)) DUT (.pclk(pclk), .presetn(presetn),
    .apb_req(req), .apb_resp(resp), .process_value(process_value),
    .pwm_pins(pwm_pins));
  pid_plant u_plant (.pclk(pclk), .pv_set(pv_set), .pin_sel(pin_sel),
    .pwm_pins(pwm_pins), .process_value(process_value), .on_len(on_len));

  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end

  task automatic tally_and_finish;
    if (fail_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    n_tests++;
    if (s !== x) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, s, x);
    end
  endtask : chk

  // an edge first, so psel never gets two assignments in one step
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd);
    int n;
    @(posedge pclk);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge pclk);
    req.penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (resp.pready === 1'b1) break;
    end
    if (n == 20) begin
      fail_count++;
      tally_and_finish();
    end
    d = resp.prdata;
    e = resp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask : apb

  task automatic w(input int i, input int v);
    apb(1'b1, 8'(i * 4), 32'(v));
    if (i != R_STATUS && i < NCFG) mdl[i] = v & 32'hFFFF;
  endtask : w

  task automatic rc(input int i);
    apb(1'b0, 8'(i * 4), 32'h0);
    chk(d, 32'(mdl[i]));
  endtask : rc

  task automatic rd(input int i);
    apb(1'b0, 8'(i * 4), 32'h0);
  endtask : rd

  task automatic ops(input int k);
    repeat (k * OPC) @(posedge pclk);
  endtask : ops

  initial begin
    req = '0;
    pv_set = 16'h0000;
    pin_sel = 5'h05;
    presetn = 1'b0;
    fail_count = 0;
    n_tests = 0;
    for (int i = 0; i < NREG; i++) mdl[i] = 0;
    mdl[R_CYCLE] = 100;
    mdl[R_KP] = 32'h100;
    mdl[R_MVMAX] = 4000;
    mdl[R_PWMPIN] = 32'h20;
    mdl[R_PWMPRD] = 100;
    mdl[R_PVMAX] = 4000;
    void'($urandom(32'hEE561A60));
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < NREG; i++) rc(i);
    apb(1'b0, 8'(NREG * 4), 32'h0);
    chk({31'h0, e}, 32'h1);
    chk(d, 32'h0);
    apb(1'b1, 8'h09, 32'h55);
    chk({31'h0, e}, 32'h1);
    w(R_MV, 5);
    rc(R_MV);
    rc(R_SV);
    // manual output drives the pulse pin
    man = 40 * $urandom_range(97, 3);
    w(R_MVMAN, man);
    w(R_PWMPIN, 32'h25);
    w(R_CTRL, 32'h13);
    ops(3);
    mdl[R_MV] = man;
    mdl[R_STATUS] = 1;
    rc(R_MV);
    rc(R_STATUS);
    chk(32'(on_len), 32'(100 * man / 4000 * UC));
    // saturate high, then flip direction to saturate low
    w(R_CTRL, 0);
    w(R_MVMAX, 2000);
    w(R_SV, 3000);
    w(R_CTRL, 1);
    ops(3);
    mdl[R_MV] = 2000;
    mdl[R_STATUS] = 32'h0103;
    rc(R_MV);
    rc(R_STATUS);
    w(R_STATUS, 2);
    rd(R_STATUS);
    chk(d & 32'h7, 32'h1);
    w(R_CTRL, 0);
    w(R_MVMIN, 100);
    w(R_CTRL, 5);
    ops(3);
    mdl[R_MV] = 100;
    mdl[R_STATUS] = 32'h0203;
    rc(R_MV);
    rc(R_STATUS);
    pv_set <= 16'd5000;
    ops(2);
    mdl[R_PVUSE] = 4000;
    rc(R_PVUSE);
    pv_set <= 16'hFF38;
    ops(2);
    mdl[R_PVUSE] = 0;
    rc(R_PVUSE);
    w(R_DPV, 10);
    pv_set <= 16'd1000;
    ops(3);
    rd(R_PVUSE);
    chk(32'(d >= 20 && d <= 50), 32'h1);
    w(R_DPV, 0);
    pv_set <= 16'd200;
    ops(2);
    // restart with follow-up from 200 toward 600
    w(R_CTRL, 0);
    w(R_TRACK, 4);
    w(R_RAMP, 4);
    w(R_SV, 600);
    w(R_CTRL, 1);
    ops(2);
    rd(R_CURSV);
    chk(32'(d > 200 && d < 600 && (d - 200) % 100 == 0), 32'h1);
    w(R_SV, 200);
    ops(6);
    mdl[R_CURSV] = 200;
    rc(R_CURSV);
    w(R_SV, 1000);
    ops(2);
    rd(R_CURSV);
    chk(32'(d > 200 && d < 1000 && d % 200 == 0), 32'h1);
    ops(4);
    mdl[R_CURSV] = 1000;
    rc(R_CURSV);
    // a cycle below the minimum is an error
    w(R_CTRL, 0);
    w(R_STATUS, 6);
    w(R_CYCLE, 99);
    w(R_CTRL, 1);
    ops(2);
    rd(R_STATUS);
    chk(d & 32'h00FF0004, 32'h00010004);
    // small error inside the deadband gives no output
    w(R_CTRL, 0);
    w(R_CYCLE, 100);
    w(R_TRACK, 0);
    w(R_RAMP, 0);
    w(R_MVMIN, 0);
    w(R_DB, 50);
    w(R_SV, 220);
    w(R_STATUS, 6);
    w(R_CTRL, 1);
    ops(2);
    mdl[R_MV] = 0;
    rc(R_MV);
    // large error: output climbs by the change limit per cycle
    w(R_DMV, 30);
    w(R_SV, 1200);
    ops(2);
    rd(R_MV);
    chk(32'(d >= 60 && d <= 90 && d % 30 == 0), 32'h1);
    tally_and_finish();
  end
endmodule : pid_loop_bench

bind pid_loop pid_loop_monitor #(.UNIT_CYCLES(UNIT_CYCLES)) u_mon (
  .pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_resp(apb_resp),
  .process_value(process_value), .pwm_pins(pwm_pins));
